// file: rtl/spbi_pkg.sv
// Constants shared by the segmented packet bus interface
package spbi_pkg;
   // Bus geometry
   localparam int SPBI_SEG_COUNT = 4;
   localparam int SPBI_SEG_DATA_W = 128;
   localparam int SPBI_CHAN_W = 11;
   localparam int SPBI_MTY_W = 4;
   localparam int SPBI_MTY_LOW_W = 3;
   // One stored segment: valid, data, channel, first, last, bad, empty count, burst word
   localparam int SPBI_SEG_ENTRY_W = 1 + SPBI_SEG_DATA_W + SPBI_CHAN_W + 3 + SPBI_MTY_W + 1;
   localparam int SPBI_ENTRY_W = SPBI_SEG_COUNT * SPBI_SEG_ENTRY_W;
   // Field positions inside one stored segment
   localparam int SPBI_F_BURST = 0;
   localparam int SPBI_F_MTY = 1;
   localparam int SPBI_F_BAD = 5;
   localparam int SPBI_F_LAST = 6;
   localparam int SPBI_F_FIRST = 7;
   localparam int SPBI_F_CHAN = 8;
   localparam int SPBI_F_DATA = 19;
   localparam int SPBI_F_VALID = 147;
   // Back-pressure
   localparam int SPBI_TX_SLACK = 8;
   localparam int SPBI_BUF_DEPTH = 32;
   localparam int SPBI_READY_MARGIN = 2;
   // Register map, byte addresses
   localparam logic [7:0] SPBI_REG_CTRL = 8'h00;
   localparam logic [7:0] SPBI_REG_STATUS = 8'h04;
   localparam logic [7:0] SPBI_REG_BURST_COUNT = 8'h08;
   // CTRL fields
   localparam int SPBI_CTRL_DRAIN_BIT = 0;
   localparam int SPBI_CTRL_MAXB_LSB = 8;
   localparam int SPBI_MAXB_W = 8;
   localparam logic SPBI_CTRL_DRAIN_RST = 1'b1;
   localparam logic [7:0] SPBI_CTRL_MAXB_RST = 8'h10;
   // STATUS fields
   localparam int SPBI_STAT_READY_BIT = 0;
   localparam int SPBI_STAT_OVF_BIT = 1;
   localparam int SPBI_STAT_FILL_LSB = 8;
endpackage

// file: rtl/spbi_buf_mem.sv
// Simple dual-port buffer memory with registered read data
`timescale 1ns/10ps
module spbi_buf_mem #(
   parameter int WIDTH = 592,
   parameter int DEPTH = 32,
   parameter int AW = 5
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   input wire logic [AW-1:0] rd_addr_i,
   output logic [WIDTH-1:0] rd_data_o
);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [WIDTH-1:0] rd_data_ff;

   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem_ff[wr_addr_i] <= wr_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_data_ff <= '0;
      end else begin
         rd_data_ff <= mem_ff[rd_addr_i];
      end
   end

   assign rd_data_o = rd_data_ff;
endmodule

// file: rtl/spbi_seg_capture.sv
// Input capture stage for one transmit segment
`timescale 1ns/10ps
module spbi_seg_capture import spbi_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic valid_i,
   input wire logic [SPBI_SEG_DATA_W-1:0] data_i,
   input wire logic [SPBI_CHAN_W-1:0] channel_i,
   input wire logic first_i,
   input wire logic last_i,
   input wire logic bad_i,
   input wire logic [SPBI_MTY_W-1:0] empty_count_i,
   input wire logic force_i,
   output logic valid_o,
   output logic [SPBI_SEG_DATA_W-1:0] data_o,
   output logic [SPBI_CHAN_W-1:0] channel_o,
   output logic first_o,
   output logic last_o,
   output logic bad_o,
   output logic [SPBI_MTY_W-1:0] empty_count_o,
   output logic force_o
);
   logic valid_ff;
   logic [SPBI_SEG_DATA_W-1:0] data_ff;
   logic [SPBI_CHAN_W-1:0] channel_ff;
   logic first_ff;
   logic last_ff;
   logic bad_ff;
   logic [SPBI_MTY_W-1:0] mty_ff;
   logic force_ff;
   wire logic bad_end = last_i & bad_i;
   wire logic [SPBI_MTY_W-1:0] nxt_mty;

   // error end clears low empty bits
   assign nxt_mty = bad_end ? {empty_count_i[SPBI_MTY_W-1], {SPBI_MTY_LOW_W{1'b0}}} :
                    empty_count_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         valid_ff <= 1'b0;
         data_ff <= '0;
         channel_ff <= '0;
         first_ff <= 1'b0;
         last_ff <= 1'b0;
         bad_ff <= 1'b0;
         mty_ff <= '0;
         force_ff <= 1'b0;
      end else begin
         valid_ff <= valid_i;
         if (valid_i) begin
            data_ff <= data_i;
            channel_ff <= channel_i;
            first_ff <= first_i;
            last_ff <= last_i;
            bad_ff <= bad_end;
            mty_ff <= last_i ? nxt_mty : '0;
            force_ff <= force_i;
         end
      end
   end

   assign valid_o = valid_ff;
   assign data_o = data_ff;
   assign channel_o = channel_ff;
   assign first_o = first_ff;
   assign last_o = last_ff;
   assign bad_o = bad_ff;
   assign empty_count_o = mty_ff;
   assign force_o = force_ff;
endmodule

// file: rtl/spbi_top.sv
// Segmented packet bus interface: transmit intake, buffer, receive output, registers
//
// Overview of operation
// - four parallel 128-bit segments, full signal sets
// - everything on rising edge of clock
// - channel and data captured only when enabled
// - segment inputs sampled only while enabled
// - bad flag sampled only with valid last
// - bad end forces low empty bits zero
// - forced flag inserts a burst control word
// - receive outputs valid only with receive valid
// - receive first and last mark packet bounds
// - receive bad meaningful only with valid last
// - receive bad end shows low empty zero
// - first byte sits in bits 127 to 120
// - empty count n voids n low bytes
// - four-bit empty count, meaningful with last only
// - overflow flags any back-pressure violation
//
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
module spbi_top import spbi_pkg::*; #(
   parameter int BUF_DEPTH = SPBI_BUF_DEPTH,
   parameter int TX_SLACK = SPBI_TX_SLACK
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [SPBI_SEG_COUNT-1:0] tx_seg_valid_i,
   input wire logic [SPBI_SEG_COUNT-1:0][SPBI_SEG_DATA_W-1:0] tx_seg_data_i,
   input wire logic [SPBI_SEG_COUNT-1:0][SPBI_CHAN_W-1:0] tx_seg_channel_i,
   input wire logic [SPBI_SEG_COUNT-1:0] tx_seg_first_i,
   input wire logic [SPBI_SEG_COUNT-1:0] tx_seg_last_i,
   input wire logic [SPBI_SEG_COUNT-1:0] tx_seg_bad_i,
   input wire logic [SPBI_SEG_COUNT-1:0][SPBI_MTY_W-1:0] tx_seg_empty_count_i,
   input wire logic [SPBI_SEG_COUNT-1:0] tx_seg_force_burst_word_i,
   output logic tx_ready_o,
   output logic tx_overflow_o,
   output logic [SPBI_SEG_COUNT-1:0] rx_seg_valid_o,
   output logic [SPBI_SEG_COUNT-1:0][SPBI_SEG_DATA_W-1:0] rx_seg_data_o,
   output logic [SPBI_SEG_COUNT-1:0][SPBI_CHAN_W-1:0] rx_seg_channel_o,
   output logic [SPBI_SEG_COUNT-1:0] rx_seg_first_o,
   output logic [SPBI_SEG_COUNT-1:0] rx_seg_last_o,
   output logic [SPBI_SEG_COUNT-1:0] rx_seg_bad_o,
   output logic [SPBI_SEG_COUNT-1:0][SPBI_MTY_W-1:0] rx_seg_empty_count_o,
   output logic [SPBI_SEG_COUNT-1:0] rx_seg_burst_word_o
);
   localparam int PTR_W = $clog2(BUF_DEPTH);
   localparam int CNT_W = PTR_W + 1;
   localparam logic [CNT_W-1:0] FULL_LVL = CNT_W'(BUF_DEPTH);
   localparam logic [CNT_W-1:0] READY_LVL = CNT_W'(BUF_DEPTH - TX_SLACK - SPBI_READY_MARGIN);
   localparam logic [3:0] SLACK_LVL = 4'(TX_SLACK);

   if (BUF_DEPTH < TX_SLACK + 4 || (1 << PTR_W) != BUF_DEPTH ||
       TX_SLACK < 1 || TX_SLACK > 15) begin : g_bad_params
      $error("spbi_top: depth must be a power of two of at least slack plus four");
   end

   // Captured segments
   logic [SPBI_SEG_COUNT-1:0] cap_valid;
   logic [SPBI_SEG_COUNT-1:0][SPBI_SEG_DATA_W-1:0] cap_data;
   logic [SPBI_SEG_COUNT-1:0][SPBI_CHAN_W-1:0] cap_chan;
   logic [SPBI_SEG_COUNT-1:0] cap_first;
   logic [SPBI_SEG_COUNT-1:0] cap_last;
   logic [SPBI_SEG_COUNT-1:0] cap_bad;
   logic [SPBI_SEG_COUNT-1:0][SPBI_MTY_W-1:0] cap_mty;
   logic [SPBI_SEG_COUNT-1:0] cap_force;

   // Burst tracking and buffer control
   logic [SPBI_CHAN_W-1:0] cur_chan_ff;
   logic [SPBI_MAXB_W-1:0] burst_cnt_ff;
   logic [SPBI_CHAN_W-1:0] nxt_cur_chan;
   logic [SPBI_MAXB_W-1:0] nxt_burst_cnt;
   logic [SPBI_SEG_COUNT-1:0] nxt_burst;
   logic [2:0] burst_add;
   logic [SPBI_ENTRY_W-1:0] wr_entry;
   logic [SPBI_ENTRY_W-1:0] rd_entry;
   logic [PTR_W-1:0] wr_ptr_ff;
   logic [PTR_W-1:0] rd_ptr_ff;
   logic [CNT_W-1:0] fill_ff;
   logic [CNT_W-1:0] nxt_fill;
   logic pop_d_ff;
   logic ready_ff;
   logic [3:0] slack_cnt_ff;
   logic ovf_ff;

   // Registers
   logic ack_ff;
   logic [31:0] dat_ff;
   logic drain_en_ff;
   logic [SPBI_MAXB_W-1:0] max_burst_length_ff;
   logic ovf_sticky_ff;
   logic [31:0] burst_total_ff;

   for (genvar s = 0; s < SPBI_SEG_COUNT; s++) begin : g_seg
      // segment inputs gated by its own valid
      spbi_seg_capture u_cap (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .valid_i(tx_seg_valid_i[s]),
         .data_i(tx_seg_data_i[s]),
         .channel_i(tx_seg_channel_i[s]),
         .first_i(tx_seg_first_i[s]),
         .last_i(tx_seg_last_i[s]),
         .bad_i(tx_seg_bad_i[s]),
         .empty_count_i(tx_seg_empty_count_i[s]),
         .force_i(tx_seg_force_burst_word_i[s]),
         .valid_o(cap_valid[s]),
         .data_o(cap_data[s]),
         .channel_o(cap_chan[s]),
         .first_o(cap_first[s]),
         .last_o(cap_last[s]),
         .bad_o(cap_bad[s]),
         .empty_count_o(cap_mty[s]),
         .force_o(cap_force[s])
      );
      // data stored unshifted, byte order kept
      assign wr_entry[s*SPBI_SEG_ENTRY_W +: SPBI_SEG_ENTRY_W] = {cap_valid[s], cap_data[s],
         cap_chan[s], cap_first[s], cap_last[s], cap_bad[s], cap_mty[s], nxt_burst[s]};
   end

   // burst word on start, force, channel change or length
   always_comb begin
      nxt_cur_chan = cur_chan_ff;
      nxt_burst_cnt = burst_cnt_ff;
      nxt_burst = '0;
      burst_add = 3'h0;
      for (int s = 0; s < SPBI_SEG_COUNT; s++) begin
         if (cap_valid[s]) begin
            if (cap_first[s] || cap_force[s] || cap_chan[s] != nxt_cur_chan ||
                nxt_burst_cnt >= max_burst_length_ff) begin
               nxt_burst[s] = 1'b1;
               nxt_burst_cnt = 8'h01;
               burst_add = burst_add + 3'h1;
            end else begin
               nxt_burst_cnt = nxt_burst_cnt + 8'h01;
            end
            nxt_cur_chan = cap_chan[s];
         end
      end
   end

   wire logic push = (|cap_valid) && (fill_ff != FULL_LVL);
   wire logic pop = drain_en_ff && (fill_ff != '0);
   wire logic in_write = |tx_seg_valid_i;
   // write past slack or into a full buffer
   wire logic ovf_evt = (in_write && !ready_ff && slack_cnt_ff == SLACK_LVL) ||
                        ((|cap_valid) && fill_ff == FULL_LVL);

   assign nxt_fill = fill_ff + CNT_W'(push) - CNT_W'(pop);

   spbi_buf_mem #(
      .WIDTH(SPBI_ENTRY_W),
      .DEPTH(BUF_DEPTH),
      .AW(PTR_W)
   ) u_mem (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_en_i(push),
      .wr_addr_i(wr_ptr_ff),
      .wr_data_i(wr_entry),
      .rd_addr_i(rd_ptr_ff),
      .rd_data_o(rd_entry)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur_chan_ff <= '0;
         burst_cnt_ff <= '0;
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         fill_ff <= '0;
         pop_d_ff <= 1'b0;
      end else begin
         if (push) begin
            cur_chan_ff <= nxt_cur_chan;
            burst_cnt_ff <= nxt_burst_cnt;
            wr_ptr_ff <= wr_ptr_ff + PTR_W'(1);
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + PTR_W'(1);
         end
         fill_ff <= nxt_fill;
         pop_d_ff <= pop;
      end
   end

   // ready tracks room for the eight-write slack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ready_ff <= 1'b0;
         slack_cnt_ff <= '0;
         ovf_ff <= 1'b0;
      end else begin
         ready_ff <= nxt_fill < READY_LVL;
         if (ready_ff) begin
            slack_cnt_ff <= '0;
         end else if (in_write && slack_cnt_ff != SLACK_LVL) begin
            slack_cnt_ff <= slack_cnt_ff + 4'h1;
         end
         ovf_ff <= ovf_evt;
      end
   end

   assign tx_ready_o = ready_ff;
   assign tx_overflow_o = ovf_ff;

   // Receive side: buffered segments leave with no back-pressure
   for (genvar s = 0; s < SPBI_SEG_COUNT; s++) begin : g_rx
      wire logic [SPBI_SEG_ENTRY_W-1:0] ent = rd_entry[s*SPBI_SEG_ENTRY_W +: SPBI_SEG_ENTRY_W];
      wire logic rx_vld = pop_d_ff && ent[SPBI_F_VALID];
      wire logic rx_end = rx_vld && ent[SPBI_F_LAST];
      wire logic rx_bad = rx_end && ent[SPBI_F_BAD];
      logic valid_ff;
      logic [SPBI_SEG_DATA_W-1:0] data_ff;
      logic [SPBI_CHAN_W-1:0] chan_ff;
      logic first_ff;
      logic last_ff;
      logic bad_ff;
      logic [SPBI_MTY_W-1:0] mty_ff;
      logic burst_ff;

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            valid_ff <= 1'b0;
            data_ff <= '0;
            chan_ff <= '0;
            first_ff <= 1'b0;
            last_ff <= 1'b0;
            bad_ff <= 1'b0;
            mty_ff <= '0;
            burst_ff <= 1'b0;
         end else begin
            valid_ff <= rx_vld;
            data_ff <= rx_vld ? ent[SPBI_F_DATA +: SPBI_SEG_DATA_W] : '0;
            chan_ff <= rx_vld ? ent[SPBI_F_CHAN +: SPBI_CHAN_W] : '0;
            first_ff <= rx_vld && ent[SPBI_F_FIRST];
            last_ff <= rx_end;
            // bad shown only with valid last
            bad_ff <= rx_bad;
            // bad end shows low empty bits zero
            if (rx_bad) begin
               mty_ff <= {ent[SPBI_F_MTY + SPBI_MTY_W - 1], {SPBI_MTY_LOW_W{1'b0}}};
            end else begin
               mty_ff <= rx_end ? ent[SPBI_F_MTY +: SPBI_MTY_W] : '0;
            end
            burst_ff <= rx_vld && ent[SPBI_F_BURST];
         end
      end

      assign rx_seg_valid_o[s] = valid_ff;
      assign rx_seg_data_o[s] = data_ff;
      assign rx_seg_channel_o[s] = chan_ff;
      assign rx_seg_first_o[s] = first_ff;
      assign rx_seg_last_o[s] = last_ff;
      assign rx_seg_bad_o[s] = bad_ff;
      assign rx_seg_empty_count_o[s] = mty_ff;
      assign rx_seg_burst_word_o[s] = burst_ff;
   end

   // Wishbone slave: one-cycle answer, unmapped reads give zero
   wire logic wb_hit = wb_cyc_i && wb_stb_i && !ack_ff;
   wire logic wb_wr = wb_hit && wb_we_i;
   wire logic sel_ctrl = wb_adr_i == SPBI_REG_CTRL;
   wire logic sel_stat = wb_adr_i == SPBI_REG_STATUS;
   wire logic sel_bcnt = wb_adr_i == SPBI_REG_BURST_COUNT;
   wire logic ovf_clr = wb_wr && sel_stat && wb_sel_i[0] && wb_dat_i[SPBI_STAT_OVF_BIT];
   wire logic bcnt_clr = wb_wr && sel_bcnt && (|wb_sel_i);
   wire logic [31:0] bcnt_add = push ? {29'h0, burst_add} : 32'h0;
   wire logic [31:0] ctrl_word = {16'h0, max_burst_length_ff, 7'h0, drain_en_ff};
   wire logic [31:0] stat_word = {{(24 - CNT_W){1'b0}}, fill_ff, 6'h0, ovf_sticky_ff, ready_ff};
   wire logic [31:0] rd_word = sel_ctrl ? ctrl_word :
                               sel_stat ? stat_word :
                               sel_bcnt ? burst_total_ff : 32'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= '0;
         drain_en_ff <= SPBI_CTRL_DRAIN_RST;
         max_burst_length_ff <= SPBI_CTRL_MAXB_RST;
         ovf_sticky_ff <= 1'b0;
         burst_total_ff <= '0;
      end else begin
         ack_ff <= wb_hit;
         dat_ff <= (wb_hit && !wb_we_i) ? rd_word : 32'h0;
         if (wb_wr && sel_ctrl && wb_sel_i[0]) begin
            drain_en_ff <= wb_dat_i[SPBI_CTRL_DRAIN_BIT];
         end
         if (wb_wr && sel_ctrl && wb_sel_i[1]) begin
            max_burst_length_ff <= wb_dat_i[SPBI_CTRL_MAXB_LSB +: SPBI_MAXB_W];
         end
         // New overflow wins over a clear in the same cycle
         ovf_sticky_ff <= ovf_evt || (ovf_sticky_ff && !ovf_clr);
         burst_total_ff <= (bcnt_clr ? 32'h0 : burst_total_ff) + bcnt_add;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
endmodule

// file: verif/spbi_top_properties.sv
// Port checker for the segmented packet bus interface
`timescale 1ns/10ps
module spbi_top_properties #(
   parameter int BUF_DEPTH = 32,
   parameter int TX_SLACK = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [3:0] tx_seg_valid_i,
   input wire logic tx_ready_o,
   input wire logic tx_overflow_o,
   input wire logic [3:0] rx_seg_valid_o,
   input wire logic [3:0][127:0] rx_seg_data_o,
   input wire logic [3:0][10:0] rx_seg_channel_o,
   input wire logic [3:0] rx_seg_first_o,
   input wire logic [3:0] rx_seg_last_o,
   input wire logic [3:0] rx_seg_bad_o,
   input wire logic [3:0][3:0] rx_seg_empty_count_o,
   input wire logic [3:0] rx_seg_burst_word_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_wb_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_ack_single_pulse: assert property (s_wb_req |=> s_ack_pulse)
      else $error("ack not one cycle after request");
   a_rdata_zero_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_ovf_needs_write: assert property (
      tx_overflow_o |-> $past(tx_seg_valid_i) != 4'h0 && !$past(tx_ready_o))
      else $error("overflow without late write");
   a_ready_after_reset: assert property (
      $fell(rst_i) |-> !tx_ready_o ##[1:2] tx_ready_o)
      else $error("ready not raised after reset");
   for (genvar s = 0; s < 4; s++) begin : g_seg
      a_rx_idle_zero: assert property (
         !rx_seg_valid_o[s] |-> {rx_seg_data_o[s], rx_seg_channel_o[s], rx_seg_first_o[s],
         rx_seg_last_o[s], rx_seg_bad_o[s], rx_seg_empty_count_o[s],
         rx_seg_burst_word_o[s]} == '0)
         else $error("idle segment fields set");
      a_bad_low_zero: assert property (
         rx_seg_bad_o[s] |-> rx_seg_last_o[s] && rx_seg_empty_count_o[s][2:0] == 3'h0)
         else $error("bad end with low empty bits");
      a_empty_needs_last: assert property (
         rx_seg_empty_count_o[s] != 4'h0 |-> rx_seg_valid_o[s] && rx_seg_last_o[s])
         else $error("empty count off last transfer");
      a_first_has_burst: assert property (
         rx_seg_valid_o[s] && rx_seg_first_o[s] |-> rx_seg_burst_word_o[s])
         else $error("start without burst word");
   end
endmodule
bind spbi_top spbi_top_properties #(.BUF_DEPTH(BUF_DEPTH), .TX_SLACK(TX_SLACK))
   u_spbi_top_properties (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .tx_seg_valid_i(tx_seg_valid_i), .tx_ready_o(tx_ready_o), .tx_overflow_o(tx_overflow_o),
   .rx_seg_valid_o(rx_seg_valid_o), .rx_seg_data_o(rx_seg_data_o),
   .rx_seg_channel_o(rx_seg_channel_o), .rx_seg_first_o(rx_seg_first_o),
   .rx_seg_last_o(rx_seg_last_o), .rx_seg_bad_o(rx_seg_bad_o),
   .rx_seg_empty_count_o(rx_seg_empty_count_o), .rx_seg_burst_word_o(rx_seg_burst_word_o));

// file: verif/spbi_user_model.sv
// Packet source standing in for user logic and burst scheduler
`timescale 1ns/10ps
module spbi_user_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic [2:0] nseg_i,
   input wire logic [3:0] flags_i,
   input wire logic [3:0] empty_i,
   input wire logic [10:0] chan_i,
   input wire logic [127:0] data_i,
   output logic [3:0] valid_o,
   output logic [3:0][127:0] data_o,
   output logic [3:0][10:0] chan_o,
   output logic [3:0] first_o,
   output logic [3:0] last_o,
   output logic [3:0] bad_o,
   output logic [3:0][3:0] empty_o,
   output logic [3:0] force_o
);
   logic [7:0] junk_ff;
   // Unused lines carry a pattern that changes every cycle
   always_ff @(posedge clk_i) begin
      junk_ff <= rst_i ? 8'h5A : junk_ff + 8'h35;
   end
   always_comb begin
      for (int s = 0; s < 4; s++) begin
         valid_o[s] = go_i && s < nseg_i;
         // full data on every valid segment
         data_o[s] = valid_o[s] ? data_i + 128'(s) : {16{junk_ff}};
         chan_o[s] = valid_o[s] ? chan_i : {junk_ff[2:0], junk_ff};
         first_o[s] = valid_o[s] ? flags_i[3] && s == 0 : junk_ff[0];
         last_o[s] = valid_o[s] ? flags_i[2] && s == nseg_i - 1 : junk_ff[1];
         // bad and count junk off the end
         bad_o[s] = last_o[s] && valid_o[s] ? flags_i[1] : junk_ff[2];
         empty_o[s] = last_o[s] && valid_o[s] ? empty_i : junk_ff[7:4];
         force_o[s] = valid_o[s] ? flags_i[0] && s == 0 : junk_ff[3];
      end
   end
endmodule

// file: verif/tb_spbi_top.sv
// Self-checking bench for the segmented packet bus interface
`timescale 1ns/10ps
module tb_spbi_top import spbi_pkg::*; ;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
   logic wb_ack_o, tx_ready_o, tx_overflow_o, go = 1'b0, ovf_seen = 1'b0;
   logic [2:0] c_n = 3'h0;
   logic [3:0] c_fl = 4'h0, c_e = 4'h0, tv, tf, tl, tb, tfc, rv, rf, rl, rb, rbw;
   logic [10:0] c_ch = 11'h0, prev_ch = 11'h0;
   logic [127:0] c_d = 128'h0;
   logic [3:0][127:0] td, rd;
   logic [3:0][10:0] tc, rc;
   logic [3:0][3:0] te, re;
   logic [174:0] obs, q[$];
   int n_fail = 0, total_checks = 0, n_burst = 0, n;
   integer seed = 32'h309D;
   spbi_user_model u_spbi_user_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .nseg_i(c_n),
      .flags_i(c_fl), .empty_i(c_e), .chan_i(c_ch), .data_i(c_d), .valid_o(tv), .data_o(td),
      .chan_o(tc), .first_o(tf), .last_o(tl), .bad_o(tb), .empty_o(te), .force_o(tfc));
   spbi_top #(.BUF_DEPTH(32), .TX_SLACK(8)) u_spbi_top (.clk_i(clk_i), .rst_i(rst_i),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'hF), .wb_we_i(wb_we_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .tx_seg_valid_i(tv), .tx_seg_data_i(td), .tx_seg_channel_i(tc), .tx_seg_first_i(tf),
      .tx_seg_last_i(tl), .tx_seg_bad_i(tb), .tx_seg_empty_count_i(te),
      .tx_seg_force_burst_word_i(tfc), .tx_ready_o(tx_ready_o), .tx_overflow_o(tx_overflow_o),
      .rx_seg_valid_o(rv), .rx_seg_data_o(rd), .rx_seg_channel_o(rc), .rx_seg_first_o(rf),
      .rx_seg_last_o(rl), .rx_seg_bad_o(rb), .rx_seg_empty_count_o(re),
      .rx_seg_burst_word_o(rbw));
   always #5 clk_i = ~clk_i;
   task automatic chk(input logic [174:0] seen, input logic [174:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task end_sim();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task do_reset();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask
   task idle(input int k);
      repeat (k) begin
         @(posedge clk_i);
         go <= 1'b0;
      end
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      go <= 1'b0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      r = wb_dat_o;
      if (k >= 20) n_fail++;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   // Notes the expected receive word, then drives one write cycle
   task automatic send(input int k, input logic [3:0] fl, input logic [3:0] e,
      input logic [10:0] ch);
      logic [127:0] d;
      logic [3:0] v, lm;
      logic [15:0] em;
      logic bw;
      d = {$random(seed), $random(seed), $random(seed), $random(seed)};
      v = 4'hF >> (4 - k);
      lm = fl[2] ? 4'h1 << (k - 1) : 4'h0;
      em = fl[2] ? (16'(fl[1] ? {e[3], 3'b000} : e) << (4 * (k - 1))) : 16'h0;
      // word at start, force or new channel
      bw = fl[3] | fl[0] | (ch !== prev_ch);
      prev_ch = ch;
      n_burst += bw;
      q.push_back({v, 3'b000, fl[3], lm, fl[1] ? lm : 4'h0, em, d, ch, 3'b000, bw});
      @(posedge clk_i);
      {go, c_n, c_fl, c_e, c_ch, c_d} <= {1'b1, 3'(k), fl, e, ch, d};
   endtask
   always @(posedge clk_i) begin
      if (rst_i) begin
         q.delete();
      end else begin
         if (tx_overflow_o !== 1'b0) ovf_seen = 1'b1;
         obs = {rv, rf, rl, rb, re, rd[0], rc[0], rbw};
         if (rv !== 4'h0 && q.size() == 0) chk(obs, ~obs);
         else if (rv !== 4'h0) chk(obs, q.pop_front());
      end
   end
   initial begin
      #60000;
      n_fail++;
      end_sim();
   end
   initial begin
      do_reset();
      wb(1'b0, SPBI_REG_CTRL, 32'h0);
      chk(r, 32'h0000_1001);
      wb(1'b0, SPBI_REG_STATUS, 32'h0);
      chk(r, 32'h0000_0001);
      wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
      chk(r, 32'h0);
      wb(1'b0, 8'h0C, 32'h0);
      chk(r, 32'h0);
      for (int k = 0; k < 12; k++) begin
         send(k % 4 + 1, {2'b11, k[2], k == 5}, 4'($random(seed)), 11'($random(seed)));
         if (k[0]) idle(2);
      end
      send(4, 4'h8, 4'h3, 11'h2A);
      send(4, 4'h1, 4'h0, 11'h2A);
      send(2, 4'h6, 4'hF, 11'h2A);
      // Length limit of two adds a word on segment two
      wb(1'b1, SPBI_REG_CTRL, 32'h0000_0201);
      wb(1'b0, SPBI_REG_CTRL, 32'h0);
      chk(r, 32'h0000_0201);
      send(4, 4'hC, 4'h0, 11'h2A);
      q.push_back(q.pop_back() | 175'h4);
      n_burst++;
      idle(12);
      chk(q.size(), 0);
      wb(1'b0, SPBI_REG_BURST_COUNT, 32'h0);
      chk(r, n_burst);
      wb(1'b1, SPBI_REG_BURST_COUNT, 32'h0);
      wb(1'b0, SPBI_REG_BURST_COUNT, 32'h0);
      chk(r, 32'h0);
      wb(1'b1, SPBI_REG_CTRL, 32'h0000_1000);
      ovf_seen = 1'b0;
      n = 0;
      do begin
         send(1, 4'hC, 4'h0, 11'h7);
         n++;
      end while (tx_ready_o === 1'b1 && n < 40);
      repeat (6) send(1, 4'hC, 4'h0, 11'h7);
      idle(4);
      chk(ovf_seen, 1'b0);
      send(1, 4'hC, 4'h0, 11'h7);
      idle(3);
      chk(ovf_seen, 1'b1);
      wb(1'b0, SPBI_REG_STATUS, 32'h0);
      chk(r[1], 1'b1);
      wb(1'b1, SPBI_REG_STATUS, 32'h2);
      wb(1'b0, SPBI_REG_STATUS, 32'h0);
      chk(r[1], 1'b0);
      do_reset();
      wb(1'b0, SPBI_REG_CTRL, 32'h0);
      chk(r, 32'h0000_1001);
      end_sim();
   end
endmodule
